// ===== ext_mem_pkg.sv
// Constants, types and decode helpers for the external memory pin block.
`default_nettype none
package ext_mem_pkg;
    // Bus geometry.
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int ADDR_W = 22;
    localparam int SD_ADDR_W = 13;
    localparam int SD_BA_LSB = 20;
    localparam int SD_AUTO_PRE_BIT = 10;
    localparam int SD_BANKS = 2;
    localparam int IO_BANKS = 3;
    localparam int ST_BANKS = 2;
    localparam int IO_SPAN_W = 14;
    localparam logic [ADDR_W-1:0] IO_ADDR_MASK = 22'h00_3fff;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 8;

    // Idle pin levels after reset, and the active-low lane enables for each bus width.
    localparam logic [LANES-1:0] MASK_IDLE = 4'hf;
    localparam logic [LANES-1:0] LANES_OFF_N = 4'hf;
    localparam logic [LANES-1:0] LANES_8_N = 4'he;
    localparam logic [LANES-1:0] LANES_16_N = 4'hc;
    localparam logic [LANES-1:0] LANES_32_N = 4'h0;

    // Timing in nanoseconds and the derived cycle counts.
    localparam int CLK_PERIOD_NS = 25;
    localparam int TRCD_NS = 20;
    localparam int TRP_NS = 20;
    localparam int TWR_NS = 15;
    localparam int CAS_LATENCY = 2;
    localparam int STATIC_ACCESS_CYCLES = 4;

    // Least times round up, and never below one cycle.
    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int TRCD_CYC = min_cycles(TRCD_NS);
    localparam int TRP_CYC = min_cycles(TRP_NS);
    localparam int TWR_CYC = min_cycles(TWR_NS);
    localparam int READ_WAIT_CYC = CAS_LATENCY + SYNC_STAGES;

    typedef enum logic [1:0] {
        SPACE_SDRAM = 2'h0,
        SPACE_STATIC = 2'h1,
        SPACE_IO = 2'h2
    } space_t;

    typedef enum logic [1:0] {
        WIDTH_8 = 2'h1,
        WIDTH_16 = 2'h2,
        WIDTH_32 = 2'h3
    } width_t;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_SD_ACT = 9'h002,
        S_SD_RCD = 9'h004,
        S_SD_CMD = 9'h008,
        S_SD_LAT = 9'h010,
        S_SD_PRE = 9'h020,
        S_ST_ACC = 9'h040,
        S_ST_GAP = 9'h080,
        S_DONE = 9'h100
    } state_t;

    // Active-low one-hot select; an index past the bank count selects none.
    function automatic logic [3:0] select_n(input logic [1:0] bank);
        return ~(4'h1 << bank);
    endfunction
endpackage
`default_nettype wire

// ===== mem_pin_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module mem_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_ff <= RESET_VALUE;
            sync_ff <= RESET_VALUE;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // mem_pin_sync
`default_nettype wire

// ===== external_memory_bus_pins.sv
// Pin sequencer for the shared SDRAM, static memory and external I/O bus.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Drive and receive a 32-bit data bus; static and I/O accesses can also use 8 or 16 bits.
// - One active-low SDRAM select per bank, two banks at most.
// - Active-low row strobe marks the row address phase of SDRAM commands.
// - Active-low column strobe marks the column address phase of commands.
// - SDRAM has its own write enable, apart from static and I/O strobes.
// - High mask blocks that lane: write data ignored, read output disabled.
// - Mask bits 0 to 3 cover data bytes 0 to 3 in order.
// - Three active-low I/O selects, 16KB each, only the addressed one low.
// - Slow I/O or static parts pull wait low; the access is stretched.
// - Two active-low static selects map processor addresses onto banks.
// - SDRAM row and column on address 12:0, bank on address 21:20.
module external_memory_bus_pins #(
    parameter int STATIC_ACCESS_CYCLES = ext_mem_pkg::STATIC_ACCESS_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire ext_mem_pkg::space_t req_space,
    input wire logic [1:0] req_bank,
    input wire ext_mem_pkg::width_t req_width,
    input wire logic [ext_mem_pkg::ADDR_W-1:0] req_addr,
    input wire logic [ext_mem_pkg::SD_ADDR_W-1:0] req_row,
    input wire logic [ext_mem_pkg::SD_ADDR_W-1:0] req_col,
    input wire logic [ext_mem_pkg::DATA_W-1:0] req_wdata,
    input wire logic [ext_mem_pkg::LANES-1:0] req_be,
    output logic rsp_valid,
    output logic [ext_mem_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic [ext_mem_pkg::DATA_W-1:0] data_in,
    output logic [ext_mem_pkg::DATA_W-1:0] data_out,
    output logic [ext_mem_pkg::LANES-1:0] data_oe_n,
    output logic [ext_mem_pkg::ADDR_W-1:0] addr_out,
    output logic [ext_mem_pkg::SD_BANKS-1:0] sdram_bank_select_n,
    output logic sdram_row_strobe_n,
    output logic sdram_column_strobe_n,
    output logic sdram_write_enable_n,
    output logic [ext_mem_pkg::LANES-1:0] sdram_byte_mask,
    output logic [ext_mem_pkg::IO_BANKS-1:0] io_bank_select_n,
    output logic [ext_mem_pkg::ST_BANKS-1:0] static_bank_select_n,
    output logic static_output_enable_n,
    output logic [ext_mem_pkg::LANES-1:0] static_write_enable_n,
    input wire logic external_wait_n
);
    import ext_mem_pkg::*;

    localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(STATIC_ACCESS_CYCLES - 1);
    localparam logic [CNT_W-1:0] TRCD_CNT = CNT_W'(TRCD_CYC - 1);
    localparam logic [CNT_W-1:0] TRP_CNT = CNT_W'(TRP_CYC - 1);
    localparam logic [CNT_W-1:0] TWR_CNT = CNT_W'(TWR_CYC - 1);
    localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_WAIT_CYC);

    state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [1:0] beat_ff, nxt_beat;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic rsp_valid_ff, nxt_rsp_valid;
    logic write_ff;
    space_t space_ff;
    logic [1:0] bank_ff;
    width_t width_ff;
    logic [ADDR_W-1:0] req_addr_ff;
    logic [SD_ADDR_W-1:0] row_ff, col_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [LANES-1:0] be_ff;
    logic wait_n_sync;
    logic [DATA_W-1:0] data_sync;

    // Pin registers and their next values.
    logic [ADDR_W-1:0] addr_pin_ff, nxt_addr_pin;
    logic [DATA_W-1:0] dout_ff, nxt_dout;
    logic [LANES-1:0] doe_n_ff, nxt_doe_n;
    logic [SD_BANKS-1:0] sd_cs_n_ff, nxt_sd_cs_n;
    logic ras_n_ff, nxt_ras_n, cas_n_ff, nxt_cas_n, sd_we_n_ff, nxt_sd_we_n;
    logic [LANES-1:0] mask_ff, nxt_mask;
    logic [IO_BANKS-1:0] io_cs_n_ff, nxt_io_cs_n;
    logic [ST_BANKS-1:0] st_cs_n_ff, nxt_st_cs_n;
    logic st_oe_n_ff, nxt_st_oe_n;
    logic [LANES-1:0] st_we_n_ff, nxt_st_we_n;

    // Both inputs come from pins, so each crosses two flip-flops first.
    mem_pin_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_wait_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(external_wait_n),
        .sync_out(wait_n_sync)
    );

    mem_pin_sync #(.WIDTH(DATA_W), .RESET_VALUE('0)) u_data_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(data_in),
        .sync_out(data_sync)
    );

    // Beat decode for narrow buses: lane, address step and byte enables.
    logic take, beat_last;
    logic [ADDR_W-1:0] beat_off, beat_addr, static_addr;
    logic [DATA_W-1:0] beat_wdata;
    logic [LANES-1:0] beat_be, beat_oe_n, sd_sel_n, ext_sel_n;
    logic [ADDR_W-1:0] sd_row_addr, sd_col_addr;
    assign take = req_valid && (state_ff == S_IDLE);
    assign beat_last = (width_ff == WIDTH_32) ||
                       (width_ff == WIDTH_16 && beat_ff == 2'h1) ||
                       (beat_ff == 2'h3);
    assign beat_off = (width_ff == WIDTH_8) ? {20'h0_0000, beat_ff} :
                      (width_ff == WIDTH_16) ? {19'h0_0000, beat_ff, 1'b0} :
                      '0;
    assign beat_addr = req_addr_ff + beat_off;
    assign static_addr = (space_ff == SPACE_IO) ?
                         (beat_addr & IO_ADDR_MASK) : beat_addr;
    assign beat_wdata = (width_ff == WIDTH_8) ?
                        {24'h00_0000, wdata_ff[8*beat_ff +: 8]} :
                        (width_ff == WIDTH_16) ?
                        {16'h0000, wdata_ff[16*beat_ff[0] +: 16]} :
                        wdata_ff;
    assign beat_be = (width_ff == WIDTH_8) ? {3'h0, be_ff[beat_ff]} :
                     (width_ff == WIDTH_16) ?
                     {2'h0, be_ff[2*beat_ff[0] +: 2]} : be_ff;
    assign beat_oe_n = (width_ff == WIDTH_8) ? LANES_8_N :
                       (width_ff == WIDTH_16) ? LANES_16_N : LANES_32_N;
    assign sd_sel_n = select_n({1'b0, bank_ff[0]});
    assign ext_sel_n = select_n(bank_ff);
    assign sd_row_addr = {req_addr_ff[ADDR_W-1:SD_BA_LSB],
                          {(SD_BA_LSB-SD_ADDR_W){1'b0}}, row_ff};
    assign sd_col_addr = {req_addr_ff[ADDR_W-1:SD_BA_LSB],
                          {(SD_BA_LSB-SD_ADDR_W){1'b0}}, col_ff};

    // Sequencer: one request at a time; SDRAM closes its row every access.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_beat = beat_ff;
        nxt_rdata = rdata_ff;
        nxt_rsp_valid = 1'b0;
        unique case (state_ff)
            S_IDLE:
                if (req_valid)
                begin
                    nxt_beat = 2'h0;
                    nxt_cnt = (req_space == SPACE_SDRAM) ? '0 : ACCESS_CNT;
                    nxt_state = (req_space == SPACE_SDRAM) ? S_SD_ACT : S_ST_ACC;
                end
            S_SD_ACT:
            begin
                nxt_cnt = TRCD_CNT;
                nxt_state = S_SD_RCD;
            end
            S_SD_RCD:
                if (cnt_ff == '0)
                    nxt_state = S_SD_CMD;
                else
                    nxt_cnt = cnt_ff - 1'b1;
            S_SD_CMD:
            begin
                nxt_cnt = write_ff ? TWR_CNT : READ_CNT;
                nxt_state = S_SD_LAT;
            end
            S_SD_LAT:
                if (cnt_ff == '0)
                begin
                    if (!write_ff)
                        nxt_rdata = data_sync;
                    nxt_state = S_SD_PRE;
                end
                else
                    nxt_cnt = cnt_ff - 1'b1;
            S_SD_PRE:
            begin
                nxt_cnt = TRP_CNT;
                nxt_state = S_DONE;
            end
            S_ST_ACC:
                if (cnt_ff != '0)
                    nxt_cnt = cnt_ff - 1'b1;
                else if (wait_n_sync)
                begin
                    if (!write_ff && width_ff == WIDTH_8)
                        nxt_rdata[8*beat_ff +: 8] = data_sync[7:0];
                    else if (!write_ff && width_ff == WIDTH_16)
                        nxt_rdata[16*beat_ff[0] +: 16] = data_sync[15:0];
                    else if (!write_ff)
                        nxt_rdata = data_sync;
                    nxt_beat = beat_ff + 2'h1;
                    nxt_state = beat_last ? S_DONE : S_ST_GAP;
                end
            S_ST_GAP:
            begin
                nxt_cnt = ACCESS_CNT;
                nxt_state = S_ST_ACC;
            end
            S_DONE:
                if (cnt_ff == '0)
                begin
                    nxt_rsp_valid = 1'b1;
                    nxt_state = S_IDLE;
                end
                else
                    nxt_cnt = cnt_ff - 1'b1;
        endcase
    end

    // Pin decode; pins follow the state by one registered cycle.
    always_comb
    begin
        nxt_addr_pin = addr_pin_ff;
        nxt_dout = dout_ff;
        nxt_doe_n = LANES_OFF_N;
        nxt_sd_cs_n = '1;
        nxt_ras_n = 1'b1;
        nxt_cas_n = 1'b1;
        nxt_sd_we_n = 1'b1;
        nxt_mask = MASK_IDLE;
        nxt_io_cs_n = '1;
        nxt_st_cs_n = '1;
        nxt_st_oe_n = 1'b1;
        nxt_st_we_n = '1;
        unique case (state_ff)
            S_SD_ACT:
            begin
                nxt_sd_cs_n = sd_sel_n[SD_BANKS-1:0];
                nxt_ras_n = 1'b0;
                nxt_addr_pin = sd_row_addr;
            end
            S_SD_CMD:
            begin
                nxt_sd_cs_n = sd_sel_n[SD_BANKS-1:0];
                nxt_cas_n = 1'b0;
                nxt_sd_we_n = !write_ff;
                nxt_mask = ~be_ff;
                nxt_addr_pin = sd_col_addr;
                if (write_ff)
                begin
                    nxt_dout = wdata_ff;
                    nxt_doe_n = LANES_32_N;
                end
            end
            S_SD_LAT:
                // Read lanes stay enabled until the data has been caught.
                if (!write_ff)
                    nxt_mask = ~be_ff;
            S_SD_PRE:
            begin
                nxt_sd_cs_n = sd_sel_n[SD_BANKS-1:0];
                nxt_ras_n = 1'b0;
                nxt_sd_we_n = 1'b0;
                nxt_addr_pin[SD_AUTO_PRE_BIT] = 1'b1;
            end
            S_ST_ACC:
            begin
                if (space_ff == SPACE_IO)
                    nxt_io_cs_n = ext_sel_n[IO_BANKS-1:0];
                else
                    nxt_st_cs_n = ext_sel_n[ST_BANKS-1:0];
                nxt_addr_pin = static_addr;
                if (write_ff)
                begin
                    nxt_st_we_n = ~beat_be;
                    nxt_dout = beat_wdata;
                    nxt_doe_n = beat_oe_n;
                end
                else
                    nxt_st_oe_n = 1'b0;
            end
            S_IDLE, S_SD_RCD, S_ST_GAP, S_DONE:
            begin
            end
        endcase
    end

    // Request capture; the fields stay put until the answer.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            write_ff <= 1'b0;
            space_ff <= SPACE_SDRAM;
            bank_ff <= 2'h0;
            width_ff <= WIDTH_32;
            req_addr_ff <= '0;
            row_ff <= '0;
            col_ff <= '0;
            wdata_ff <= '0;
            be_ff <= '0;
        end
        else if (take)
        begin
            write_ff <= req_write;
            space_ff <= req_space;
            bank_ff <= req_bank;
            width_ff <= req_width;
            req_addr_ff <= req_addr;
            row_ff <= req_row;
            col_ff <= req_col;
            wdata_ff <= req_wdata;
            be_ff <= req_be;
        end
    end

    // Sequencer state.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= S_IDLE;
            cnt_ff <= '0;
            beat_ff <= 2'h0;
            rdata_ff <= '0;
            rsp_valid_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            beat_ff <= nxt_beat;
            rdata_ff <= nxt_rdata;
            rsp_valid_ff <= nxt_rsp_valid;
        end
    end

    // Pin registers, so no strobe can glitch on the board.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {addr_pin_ff, dout_ff} <= '0;
            {doe_n_ff, mask_ff, st_we_n_ff} <= '1;
            {sd_cs_n_ff, io_cs_n_ff, st_cs_n_ff} <= '1;
            {ras_n_ff, cas_n_ff, sd_we_n_ff, st_oe_n_ff} <= 4'hf;
        end
        else
        begin
            {addr_pin_ff, dout_ff} <= {nxt_addr_pin, nxt_dout};
            {doe_n_ff, mask_ff, st_we_n_ff} <= {nxt_doe_n, nxt_mask, nxt_st_we_n};
            {sd_cs_n_ff, io_cs_n_ff, st_cs_n_ff} <=
                {nxt_sd_cs_n, nxt_io_cs_n, nxt_st_cs_n};
            {ras_n_ff, cas_n_ff, sd_we_n_ff, st_oe_n_ff} <=
                {nxt_ras_n, nxt_cas_n, nxt_sd_we_n, nxt_st_oe_n};
        end
    end

    assign req_ready = (state_ff == S_IDLE);
    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rdata_ff;
    assign data_out = dout_ff;
    assign data_oe_n = doe_n_ff;
    assign addr_out = addr_pin_ff;
    assign sdram_bank_select_n = sd_cs_n_ff;
    assign sdram_row_strobe_n = ras_n_ff;
    assign sdram_column_strobe_n = cas_n_ff;
    assign sdram_write_enable_n = sd_we_n_ff;
    assign sdram_byte_mask = mask_ff;
    assign io_bank_select_n = io_cs_n_ff;
    assign static_bank_select_n = st_cs_n_ff;
    assign static_output_enable_n = st_oe_n_ff;
    assign static_write_enable_n = st_we_n_ff;

    // Checks on the pin behaviour.
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_data_drive_write: assert property (
        (data_oe_n != LANES_OFF_N) |-> write_ff && sdram_row_strobe_n)
        else $error("Data bus driven outside a write.");
    chk_sd_one_bank: assert property (
        $onehot0(~sdram_bank_select_n))
        else $error("More than one SDRAM bank selected.");
    chk_row_phase: assert property (
        (!sdram_row_strobe_n && sdram_write_enable_n) |->
        (sdram_bank_select_n != 2'h3) ##1 sdram_row_strobe_n ##1
        sdram_row_strobe_n)
        else $error("Row strobe phase malformed.");
    chk_col_phase: assert property (
        !sdram_column_strobe_n |-> sdram_row_strobe_n &&
        !addr_out[SD_AUTO_PRE_BIT] && addr_out[SD_ADDR_W-1:0] == col_ff ##1
        sdram_column_strobe_n)
        else $error("Column phase malformed.");
    chk_sd_we_own: assert property (
        !sdram_write_enable_n |-> (&static_write_enable_n) &&
        static_output_enable_n && (&static_bank_select_n))
        else $error("SDRAM write enable shared with static strobes.");
    chk_mask_write_data: assert property (
        (!sdram_column_strobe_n && !sdram_write_enable_n) |->
        data_oe_n == LANES_32_N && data_out == wdata_ff)
        else $error("SDRAM write data not on the bus.");
    chk_mask_lane_map: assert property (
        !sdram_column_strobe_n |-> sdram_byte_mask == ~be_ff)
        else $error("Byte mask lanes mismatched.");
    chk_io_select: assert property (
        $onehot0(~io_bank_select_n) && ((&io_bank_select_n) ||
        addr_out[ADDR_W-1:IO_SPAN_W] == '0))
        else $error("I/O bank select or span wrong.");
    chk_wait_hold: assert property (
        (state_ff == S_ST_ACC && cnt_ff == '0 && !wait_n_sync) |=>
        (state_ff == S_ST_ACC) ##1 ($stable(static_bank_select_n) &&
        $stable(io_bank_select_n) && $stable(static_output_enable_n) &&
        $stable(static_write_enable_n) && $stable(addr_out) &&
        $stable(data_out)))
        else $error("Strobes moved while wait was held.");
    chk_static_select: assert property (
        $onehot0(~static_bank_select_n) &&
        !(!(&static_bank_select_n) && !(&io_bank_select_n)))
        else $error("Static select not exclusive.");
    chk_sd_bank_addr: assert property (
        (!sdram_row_strobe_n && sdram_write_enable_n) |->
        addr_out[ADDR_W-1:SD_BA_LSB] == req_addr_ff[ADDR_W-1:SD_BA_LSB] &&
        addr_out[SD_ADDR_W-1:0] == row_ff)
        else $error("SDRAM row or bank address wrong.");
endmodule // external_memory_bus_pins
`default_nettype wire

// ===== ext_mem_partner.sv
// Behavioural model of the SDRAM, static memory and I/O parts.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_partner
(
    input wire logic clk,
    input wire logic [21:0] addr_out,
    input wire logic [1:0] sdram_bank_select_n,
    input wire logic sdram_row_strobe_n,
    input wire logic sdram_column_strobe_n,
    input wire logic sdram_write_enable_n,
    input wire logic [3:0] sdram_byte_mask,
    input wire logic [2:0] io_bank_select_n,
    input wire logic [1:0] static_bank_select_n,
    input wire logic static_output_enable_n,
    input wire logic [3:0] wait_cycles,
    output logic [31:0] data_in,
    output logic external_wait_n
);
    logic [31:0] sd_q;
    logic [31:0] sd_word;
    logic [3:0] sd_lanes;
    logic sd_lat;
    logic [3:0] wait_left;
    logic st_sel;
    logic st_sel_d;
    logic sd_read;
    // Static and I/O parts answer from the address while enabled.
    assign st_sel = (static_bank_select_n != 2'h3) || (io_bank_select_n != 3'h7);
    assign sd_read = (sdram_bank_select_n != 2'h3) && sdram_row_strobe_n &&
        !sdram_column_strobe_n && sdram_write_enable_n;
    assign data_in = (st_sel && !static_output_enable_n) ?
        (32'ha5a5_0000 ^ {10'h000, addr_out}) : sd_q;
    // A slow part pulls wait low as soon as it sees its select fall.
    assign external_wait_n = !((st_sel && !st_sel_d && wait_cycles != 4'h0) ||
        wait_left != 4'h0);
    initial
    begin
        sd_q = 32'h0000_0000;
        sd_lat = 1'b0;
        wait_left = 4'h0;
        st_sel_d = 1'b0;
    end
    // Read data shows one edge after the command and stands one cycle only,
    // so a late sample sees a changing pattern; masked lanes never drive.
    always @(posedge clk)
    begin
        st_sel_d <= st_sel;
        if (st_sel && !st_sel_d && wait_cycles != 4'h0)
            wait_left <= wait_cycles - 4'h1;
        else if (wait_left != 4'h0)
            wait_left <= wait_left - 4'h1;
        sd_lat <= sd_read;
        if (sd_read)
        begin
            sd_word <= 32'h5a5a_0000 ^ {19'h0_0000, addr_out[12:0]};
            sd_lanes <= sdram_byte_mask;
        end
        for (int i = 0; i < 4; i++)
            sd_q[i*8+:8] <= (sd_lat && !sd_lanes[i]) ?
                sd_word[i*8+:8] : ~sd_q[i*8+:8];
    end
endmodule // ext_mem_partner
`default_nettype wire

// ===== external_memory_bus_pins_bench.sv
// Self-checking bench for the external memory pin sequencer.
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_pins_bench;
    import ext_mem_pkg::*;
    logic clk, resetn, req_valid, req_ready, req_write, rsp_valid;
    space_t req_space;
    width_t req_width;
    logic [1:0] req_bank, sd_cs, col_c, st_s;
    logic [21:0] req_addr, addr_out, act_a, col_a, io_a;
    logic [12:0] req_row, req_col;
    logic [31:0] req_wdata, rsp_rdata, data_in, data_out, col_d;
    logic [3:0] req_be, data_oe_n, mask, st_we, col_m, wait_cycles;
    logic ras_n, cas_n, sd_we_n, oe_n, wait_n, col_w, we_p, bad_we;
    logic [2:0] io_sel, io_s;
    int errors = 0;
    int check_count = 0;
    int beats = 0;
    int lat;
    external_memory_bus_pins i_external_memory_bus_pins (.clk(clk),
        .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_space(req_space), .req_bank(req_bank),
        .req_width(req_width), .req_addr(req_addr), .req_row(req_row),
        .req_col(req_col), .req_wdata(req_wdata), .req_be(req_be),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .addr_out(addr_out),
        .sdram_bank_select_n(sd_cs), .sdram_row_strobe_n(ras_n),
        .sdram_column_strobe_n(cas_n), .sdram_write_enable_n(sd_we_n),
        .sdram_byte_mask(mask), .io_bank_select_n(io_sel),
        .static_bank_select_n(st_s), .static_output_enable_n(oe_n),
        .static_write_enable_n(st_we), .external_wait_n(wait_n));
    ext_mem_partner i_ext_mem_partner (.clk(clk), .addr_out(addr_out),
        .sdram_bank_select_n(sd_cs), .sdram_row_strobe_n(ras_n),
        .sdram_column_strobe_n(cas_n), .sdram_write_enable_n(sd_we_n),
        .sdram_byte_mask(mask), .io_bank_select_n(io_sel),
        .static_bank_select_n(st_s), .static_output_enable_n(oe_n),
        .wait_cycles(wait_cycles), .data_in(data_in),
        .external_wait_n(wait_n));
    // Record the pin values of each command phase for later judgement.
    always @(posedge clk)
    begin
        we_p <= st_we != 4'hf;
        if (st_we != 4'hf && !we_p)
            beats <= beats + 1;
        if (!sd_we_n && st_we != 4'hf)
            bad_we <= 1'b1;
        if (!ras_n && cas_n && sd_we_n)
            act_a <= addr_out;
        if (!cas_n)
            {col_a, col_m, col_c, col_d, col_w} <=
                {addr_out, mask, sd_cs, data_out, sd_we_n};
        if (io_sel != 3'h7)
            {io_s, io_a} <= {io_sel, addr_out};
        if (st_s != 2'h3)
            col_c <= st_s;
    end
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Offer one request, then wait a bounded time for its answer.
    task automatic go(input logic wr, space_t sp, width_t w, logic [1:0] b,
        logic [21:0] a, logic [3:0] be);
        {req_write, req_space, req_width, req_bank} = {wr, sp, w, b};
        {req_addr, req_be, req_valid, beats, bad_we} = {a, be, 1'b1, 32'h0, 1'b0};
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        lat = 0;
        do begin @(posedge clk); #1; lat++; end
        while (rsp_valid !== 1'b1 && lat < 300);
        if (lat >= 300)
            errors++;
        @(negedge clk);
    endtask
    task automatic idle_pins();
        chk("sd cs", {30'h0, sd_cs}, 32'h3);
        chk("sd cmd", {29'h0, ras_n, cas_n, sd_we_n}, 32'h7);
        chk("io sel", {29'h0, io_sel}, 32'h7);
        chk("st sel", {30'h0, st_s}, 32'h3);
        chk("mask oe", {24'h0, mask, data_oe_n}, 32'hff);
    endtask
    task automatic sd_read();
        {req_row, req_col} = {13'h1abc, 13'h0123};
        go(1'b0, SPACE_SDRAM, WIDTH_32, 2'h1, 22'h30_0000, 4'h5);
        chk("bank addr", {30'h0, act_a[21:20]}, 32'h3);
        chk("row", {19'h0, act_a[12:0]}, 32'h1abc);
        chk("col", {19'h0, col_a[12:0]}, 32'h123);
        chk("cs", {30'h0, col_c}, 32'h1);
        chk("mask", {28'h0, col_m}, 32'ha);
        chk("rd we", {31'h0, col_w}, 32'h1);
        chk("rdata", rsp_rdata & 32'h00ff_00ff, 32'h005a_0023);
    endtask
    task automatic sd_write();
        req_wdata = 32'hdead_beef;
        go(1'b1, SPACE_SDRAM, WIDTH_32, 2'h0, 22'h10_0000, 4'h9);
        chk("wdata", col_d, 32'hdead_beef);
        chk("wr we", {31'h0, col_w}, 32'h0);
        chk("static we", {31'h0, bad_we}, 32'h0);
        chk("cs", {30'h0, col_c}, 32'h2);
        chk("mask", {28'h0, col_m}, 32'h6);
    endtask
    task automatic st_read(input logic [3:0] w);
        wait_cycles = w;
        go(1'b0, SPACE_STATIC, WIDTH_32, 2'h1, 22'h00_0120, 4'hf);
        wait_cycles = 4'h0;
        chk("st sel", {30'h0, col_c}, 32'h1);
        chk("st data", rsp_rdata, 32'ha5a5_0120);
        // Each cycle of wait stretches the access by exactly one cycle.
        chk("stretch", lat, STATIC_ACCESS_CYCLES + 1 + w);
    endtask
    task automatic io_writes();
        for (int b = 0; b < 3; b++)
        begin
            go(1'b1, SPACE_IO, WIDTH_8, b[1:0], 22'h3f_c010, 4'hf);
            chk("io sel", {29'h0, io_s}, {29'h0, ~(3'h1 << b)});
            chk("io span", {24'h0, io_a[21:14]}, 32'h0);
            chk("8 bit beats", beats, 32'h4);
        end
        go(1'b1, SPACE_STATIC, WIDTH_16, 2'h0, 22'h00_0200, 4'hf);
        chk("16 bit beats", beats, 32'h2);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Cut a hang short well after the hundred or so cycles the run needs.
    initial
    begin
        #200000;
        errors++;
        finish_test();
    end
    initial
    begin
        {resetn, req_valid, req_write, req_bank, req_addr} = '0;
        {req_row, req_col, req_wdata, req_be, wait_cycles} = '0;
        {req_space, req_width, we_p, bad_we} = {SPACE_SDRAM, WIDTH_32, 2'h0};
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        idle_pins();
        sd_read();
        sd_write();
        st_read(4'h0);
        st_read(4'h3);
        io_writes();
        idle_pins();
        finish_test();
    end
endmodule // external_memory_bus_pins_bench
`default_nettype wire
